/* File: pkg/pdw_consts.svh */
`ifndef PDW_CONSTS_SVH
`define PDW_CONSTS_SVH
// ----------------------------------------
// register map (printed offsets not word aligned: index, byte = 4*index)
// ----------------------------------------
`define PDW_IDX_GATING     8'hef
`define PDW_IDX_PDCTRL     8'hf3
`define PDW_RST_GATING     8'hff
`define PDW_RST_PDCTRL     8'h01
`define PDW_BIT_PINWAKE    0
`define PDW_BIT_PDEN       1
`define PDW_BIT_MODE_LO    2
`define PDW_BIT_WKRST      4
`define PDW_MASK_PDCTRL    8'h1f
// ----------------------------------------
// timing
// ----------------------------------------
`define PDW_CLK_MHZ        125
`define PDW_PIN_MIN_NS     100
`define PDW_PIN_CYC        ((`PDW_PIN_MIN_NS * `PDW_CLK_MHZ + 999) / 1000)
`define PDW_REG_US         150
`define PDW_REG_CYC        (`PDW_REG_US * `PDW_CLK_MHZ)
`define PDW_OSC_US         10
`define PDW_OSC_CYC        (`PDW_OSC_US * `PDW_CLK_MHZ)
`define PDW_EDGE_NOWAKE    2'h3
`endif

/* File: pkg/pdw_pkg.sv */
package pdw_pkg;
   typedef enum logic [1:0] {
      PDW_MODE1,
      PDW_MODE2,
      PDW_MODE3,
      PDW_MODE4
   } pdw_mode_t;

   typedef struct packed {
      logic external_wake_pin;
      logic rtcWakeReq;
      logic crystal_loss_flag;
   } pdw_wake_t;
endpackage

/* File: rtl/pdw_delay.sv */
`timescale 1ns/1ns
// ----------------------------------------
// start-to-done delay counter
// ----------------------------------------
module pdw_delay #(
   parameter int CYCLES = 8
) (
   input  wire logic mclk,
   input  wire logic arst_n,
   input  wire logic start,
   output logic      done
);
   localparam int W = $clog2(CYCLES + 1);
   // a zero count could never raise done, so refuse it while elaborating
   if (CYCLES < 1) begin : g_bad_cycles
      $error("pdw_delay: CYCLES must be at least 1");
   end
   logic [W-1:0] cnt_q;
   logic         run_q;
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= '0;
         run_q <= 1'b0;
      end else if (start) begin
         cnt_q <= W'(CYCLES - 1);
         run_q <= 1'b1;
      end else if (run_q) begin
         if (cnt_q == '0) begin
            run_q <= 1'b0;
         end else begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
   assign done = run_q && (cnt_q == '0) && !start;
endmodule

/* File: rtl/pdw_top.sv */
`timescale 1ns/1ns
`include "pdw_consts.svh"
module pdw_top #(
   parameter int REG_CYC = `PDW_REG_CYC,
   parameter int OSC_CYC = `PDW_OSC_CYC,
   parameter int PIN_CYC = `PDW_PIN_CYC
) (
   input  wire logic              mclk,
   input  wire logic              arst_n,
   // axi4-lite slave
   input  wire logic [11:0]       s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [11:0]       s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // system side
   input  wire pdw_pkg::pdw_wake_t wakeIn,
   input  wire logic [1:0]        wake_edge_mode,
   input  wire logic              wakePinActiveHigh,
   input  wire logic              protectActive,
   output logic                   powerDown,
   output logic                   regulatorOn,
   output logic                   oscStart,
   output logic                   flashReady,
   output logic                   cpuClkEn,
   output logic                   cpuResume,
   output logic                   wakeResetReq,
   output logic                   portHold,
   output logic                   rtcStopped,
   input  wire logic              rtcEnableSet,
   output logic [2:0]             wakeSource,
   output logic                   wakeIrq,
   output logic [7:0]             peripheral_clock_gating
);
   // refused while elaborating: a zero count would skip a wake step
   if (PIN_CYC < 1 || REG_CYC < 1 || OSC_CYC < 1) begin : g_bad_counts
      $error("pdw_top: delay counts must be at least 1");
   end
   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [7:0] gating_q;
   logic       pinWake_q;
   logic       pdEn_q;
   logic [1:0] mode_q;
   logic       wkRst_q;
   logic       wkRstEntry_q;
   pdw_pkg::pdw_mode_t modeEntry_q;
   logic       hwClearPd;
   logic       swSetPd;

   // ----------------------------------------
   // axi4-lite write channel
   // ----------------------------------------
   logic        awHeld_q;
   logic        wHeld_q;
   logic [11:0] awAddr_q;
   logic [31:0] wData_q;
   logic [3:0]  wStrb_q;
   logic        bValid_q;
   logic        doWrite;
   logic [9:0]  wIdx;
   assign s_axi_awready = !awHeld_q && !bValid_q;
   assign s_axi_wready  = !wHeld_q && !bValid_q;
   assign doWrite       = awHeld_q && wHeld_q && !bValid_q;
   assign wIdx          = awAddr_q[11:2];
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         awHeld_q <= 1'b0;
         wHeld_q  <= 1'b0;
         awAddr_q <= 12'h000;
         wData_q  <= 32'h0000_0000;
         wStrb_q  <= 4'h0;
         bValid_q <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            bValid_q <= 1'b1;
         end else if (bValid_q && s_axi_bready) begin
            bValid_q <= 1'b0;
         end
      end
   end
   assign s_axi_bvalid = bValid_q;
   assign s_axi_bresp  = 2'h0;

   logic wrGating;
   logic wrCtrl;
   assign wrGating = doWrite && wStrb_q[0] && (wIdx == 10'(`PDW_IDX_GATING));
   assign wrCtrl   = doWrite && wStrb_q[0] && (wIdx == 10'(`PDW_IDX_PDCTRL));
   assign swSetPd  = wrCtrl && wData_q[`PDW_BIT_PDEN] && !protectActive;

   // ----------------------------------------
   // register storage
   // ----------------------------------------
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         gating_q <= `PDW_RST_GATING;
      end else if (wrGating) begin
         gating_q <= wData_q[7:0];
      end
   end
   assign peripheral_clock_gating = gating_q;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pinWake_q <= 1'(`PDW_RST_PDCTRL >> `PDW_BIT_PINWAKE);
         mode_q    <= 2'h0;
         wkRst_q   <= 1'b0;
      end else if (wrCtrl) begin
         pinWake_q <= wData_q[`PDW_BIT_PINWAKE];
         mode_q    <= wData_q[`PDW_BIT_MODE_LO +: 2];
         wkRst_q   <= wData_q[`PDW_BIT_WKRST];
      end
   end

   // power-down enable: the wake-up circuit clear always wins, since a software set is ignored while powerDown is high
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pdEn_q <= 1'b0;
      end else if (swSetPd && !powerDown) begin
         pdEn_q <= 1'b1;
      end else if (hwClearPd) begin
         pdEn_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // axi4-lite read channel
   // ----------------------------------------
   logic        rValid_q;
   logic [31:0] rData_q;
   logic [9:0]  rIdx;
   logic [7:0]  rByte;
   assign s_axi_arready = !rValid_q;
   assign rIdx = s_axi_araddr[11:2];
   always_comb begin
      rByte = 8'h00;
      if (rIdx == 10'(`PDW_IDX_GATING)) begin
         rByte = gating_q;
      end else if (rIdx == 10'(`PDW_IDX_PDCTRL)) begin
         // upper three bits stay zero
         rByte = {3'h0, wkRst_q, mode_q, pdEn_q, pinWake_q};
      end
   end
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rValid_q <= 1'b0;
         rData_q  <= 32'h0000_0000;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rValid_q <= 1'b1;
         rData_q  <= {24'h00_0000, rByte};
      end else if (rValid_q && s_axi_rready) begin
         rValid_q <= 1'b0;
      end
   end
   assign s_axi_rvalid = rValid_q;
   assign s_axi_rdata  = rData_q;
   assign s_axi_rresp  = 2'h0;

   // ----------------------------------------
   // wake qualification
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_RUN,
      ST_DOWN,
      ST_REG,
      ST_OSC,
      ST_FLASH,
      ST_RESUME
   } pdw_state_t;
   pdw_state_t state_q;

   localparam int PW = $clog2(PIN_CYC + 1);
   logic [PW-1:0] pinCnt_q;
   logic          pinActive;
   logic          pinWake;
   logic          rtcWake;
   logic          lossWake;
   logic          anyWake;
   assign pinActive = (wakeIn.external_wake_pin == wakePinActiveHigh)
                      && pinWake_q
                      && (wake_edge_mode != `PDW_EDGE_NOWAKE);
   // a short pulse restarts the count, so glitches under the minimum never wake
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pinCnt_q <= '0;
      end else if (state_q != ST_DOWN || !pinActive) begin
         pinCnt_q <= '0;
      end else if (pinCnt_q != PW'(PIN_CYC)) begin
         pinCnt_q <= pinCnt_q + 1'b1;
      end
   end
   assign pinWake  = (pinCnt_q == PW'(PIN_CYC));
   assign rtcWake  = wakeIn.rtcWakeReq && (modeEntry_q != pdw_pkg::PDW_MODE1);
   assign lossWake = wakeIn.crystal_loss_flag
                     && (modeEntry_q == pdw_pkg::PDW_MODE2);
   assign anyWake  = (state_q == ST_DOWN) && (pinWake || rtcWake || lossWake);

   // ----------------------------------------
   // wake sequencer
   // ----------------------------------------
   logic regDone;
   logic oscDone;
   logic enterDown;
   assign enterDown = (state_q == ST_RUN) && pdEn_q;

   pdw_delay #(.CYCLES(REG_CYC)) u_reg_delay (
      .mclk   (mclk),
      .arst_n (arst_n),
      .start  (anyWake && !wkRstEntry_q),
      .done   (regDone)
   );
   pdw_delay #(.CYCLES(OSC_CYC)) u_osc_delay (
      .mclk   (mclk),
      .arst_n (arst_n),
      .start  (state_q == ST_REG && regDone),
      .done   (oscDone)
   );

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= ST_RUN;
      end else begin
         case (state_q)
            ST_RUN: begin
               if (enterDown) begin
                  state_q <= ST_DOWN;
               end
            end
            ST_DOWN: begin
               if (anyWake) begin
                  state_q <= wkRstEntry_q ? ST_RESUME : ST_REG;
               end
            end
            ST_REG: begin
               if (regDone) begin
                  state_q <= ST_OSC;
               end
            end
            ST_OSC: begin
               if (oscDone) begin
                  state_q <= ST_FLASH;
               end
            end
            ST_FLASH: begin
               state_q <= ST_RESUME;
            end
            ST_RESUME: begin
               state_q <= ST_RUN;
            end
            default: begin
               state_q <= ST_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         wkRstEntry_q <= 1'b0;
         modeEntry_q  <= pdw_pkg::PDW_MODE1;
      end else if (enterDown) begin
         wkRstEntry_q <= wkRst_q;
         modeEntry_q  <= pdw_pkg::pdw_mode_t'(mode_q);
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         wakeSource <= 3'h0;
      end else if (anyWake) begin
         wakeSource <= {lossWake, rtcWake, pinWake};
      end
   end

   // real-time clock stays off after mode 1 until software re-enables it
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rtcStopped <= 1'b0;
      end else if (enterDown && mode_q == 2'h0) begin
         rtcStopped <= 1'b1;
      end else if (rtcEnableSet && state_q == ST_RUN) begin
         rtcStopped <= 1'b0;
      end
   end

   assign hwClearPd    = (state_q == ST_RESUME);
   assign powerDown    = (state_q != ST_RUN);
   assign regulatorOn  = (state_q == ST_RUN) || (state_q != ST_DOWN);
   assign oscStart     = (state_q == ST_OSC) || (state_q == ST_FLASH)
                         || (state_q == ST_RESUME) || (state_q == ST_RUN);
   assign flashReady   = (state_q == ST_FLASH) || (state_q == ST_RESUME)
                         || (state_q == ST_RUN);
   assign cpuClkEn     = (state_q == ST_RUN);
   assign cpuResume    = (state_q == ST_RESUME) && !wkRstEntry_q;
   assign wakeResetReq = (state_q == ST_RESUME) && wkRstEntry_q;
   assign portHold     = (state_q != ST_RUN) && !(state_q == ST_RESUME && wkRstEntry_q);
   assign wakeIrq      = 1'b0;
endmodule

/* File: testbench/pdw_top_sva.sv */
`timescale 1ns/1ns
// ----------------------------------------
// wake sequence checker
// ----------------------------------------
module pdw_top_sva #(
   parameter int REG_CYC = 20,
   parameter int OSC_CYC = 10
) (
   input wire logic        mclk,
   input wire logic        arst_n,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        powerDown,
   input wire logic        regulatorOn,
   input wire logic        oscStart,
   input wire logic        flashReady,
   input wire logic        cpuClkEn,
   input wire logic        cpuResume,
   input wire logic        wakeResetReq,
   input wire logic        portHold,
   input wire logic        rtcStopped,
   input wire logic        rtcEnableSet,
   input wire logic        wakeIrq,
   input wire logic [7:0]  peripheral_clock_gating
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   int regCnt_q;
   int oscCnt_q;
   // phase lengths are kept so a wait is judged when the next step starts
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) regCnt_q <= 0;
      else if (!regulatorOn) regCnt_q <= 0;
      else if (!oscStart) regCnt_q <= regCnt_q + 1;
   end
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) oscCnt_q <= 0;
      else if (!oscStart) oscCnt_q <= 0;
      else if (!flashReady) oscCnt_q <= oscCnt_q + 1;
   end
   a_no_irq: assert property (!wakeIrq)
      else $error("wake source raised an interrupt");
   a_gate_reset: assert property (!$past(arst_n) |-> peripheral_clock_gating == 8'hff)
      else $error("gating not at reset value");
   a_cpu_gated: assert property (cpuClkEn |-> !powerDown && regulatorOn && oscStart && flashReady)
      else $error("cpu clock runs while down");
   a_reg_wait: assert property ($rose(oscStart) && $past(regulatorOn)
      |-> regCnt_q >= REG_CYC - 1 && regCnt_q <= REG_CYC + 2)
      else $error("regulator wait wrong");
   a_osc_wait: assert property ($rose(flashReady) && $past(oscStart)
      |-> oscCnt_q >= OSC_CYC - 1 && oscCnt_q <= OSC_CYC + 2)
      else $error("oscillator wait wrong");
   a_flash_short: assert property ($rose(flashReady) && $past(oscStart) |-> ##[1:2] cpuResume)
      else $error("flash step too long");
   a_resume_once: assert property (cpuResume |=> !cpuResume && cpuClkEn)
      else $error("resume not a single cycle into run");
   a_clk_release: assert property ($rose(cpuClkEn)
      |-> $past(cpuResume) || $past(wakeResetReq) || $past(wakeResetReq, 2))
      else $error("cpu clock released outside sequence");
   a_read_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && !s_axi_rresp)
      else $error("read upper bits or response not zero");
   a_rtc_restart: assert property ($fell(rtcStopped) |-> $past(rtcEnableSet))
      else $error("clock restarted without software");
   a_port_release: assert property (wakeResetReq |-> !portHold)
      else $error("port state still held on reset wake");
   a_port_kept: assert property (cpuResume |-> portHold)
      else $error("port state lost on fast wake");
endmodule

bind pdw_top pdw_top_sva #(.REG_CYC(REG_CYC), .OSC_CYC(OSC_CYC)) sva_u (
   .mclk, .arst_n, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .powerDown, .regulatorOn,
   .oscStart, .flashReady, .cpuClkEn, .cpuResume, .wakeResetReq, .portHold, .rtcStopped,
   .rtcEnableSet,
   .wakeIrq, .peripheral_clock_gating
);

/* File: testbench/pdw_partner.sv */
`timescale 1ns/1ns
// ----------------------------------------
// wake sources: pin, clock wake, crystal loss
// ----------------------------------------
module pdw_partner (
   input  wire logic          mclk,
   input  wire logic          arst_n,
   input  wire logic [2:0]    pulseReq,
   input  wire logic [7:0]    pulseLen,
   output pdw_pkg::pdw_wake_t wakeIn
);
   logic [7:0] left_q;
   logic [2:0] src_q;
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         left_q <= 8'h0;
         src_q  <= 3'h0;
      end else if (pulseReq != 3'h0) begin
         left_q <= pulseLen;
         src_q  <= pulseReq;
      end else if (left_q != 8'h0) left_q <= left_q - 8'h1;
   end
   // sources sit inactive outside a requested pulse
   always_comb begin
      wakeIn.external_wake_pin = src_q[0] && left_q != 8'h0;
      wakeIn.rtcWakeReq        = src_q[1] && left_q != 8'h0;
      wakeIn.crystal_loss_flag = src_q[2] && left_q != 8'h0;
   end
endmodule

/* File: testbench/pdw_top_bench.sv */
`timescale 1ns/1ns
`include "pdw_consts.svh"
// ----------------------------------------
// power-down wake bench
// ----------------------------------------
module pdw_top_bench;
   localparam int          RC     = 20;
   localparam int          OC     = 10;
   localparam logic [11:0] A_GATE = {2'h0, `PDW_IDX_GATING, 2'h0};
   localparam logic [11:0] A_CTRL = {2'h0, `PDW_IDX_PDCTRL, 2'h0};
   logic               mclk, arst_n, wakePinActiveHigh, protectActive, rtcEnableSet;
   logic [11:0]        s_axi_awaddr, s_axi_araddr;
   logic [31:0]        s_axi_wdata, s_axi_rdata;
   logic [3:0]         s_axi_wstrb;
   logic [1:0]         s_axi_bresp, s_axi_rresp, wake_edge_mode;
   logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic               s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic               powerDown, regulatorOn, oscStart, flashReady, cpuClkEn, cpuResume;
   logic               wakeResetReq, rtcStopped, wakeIrq, portHold;
   logic [2:0]         wakeSource, pReq;
   logic [7:0]         peripheral_clock_gating, pLen;
   pdw_pkg::pdw_wake_t wakeIn;
   int                 errorCnt, testsRun, cyc, resCnt, rstCnt;

   pdw_top #(.REG_CYC(RC), .OSC_CYC(OC), .PIN_CYC(3)) dut_u (
      .mclk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .wakeIn, .wake_edge_mode, .wakePinActiveHigh, .protectActive, .powerDown,
      .regulatorOn, .oscStart, .flashReady, .cpuClkEn, .cpuResume, .wakeResetReq, .portHold,
      .rtcStopped, .rtcEnableSet, .wakeSource, .wakeIrq, .peripheral_clock_gating
   );
   pdw_partner far_u (.mclk, .arst_n, .pulseReq(pReq), .pulseLen(pLen), .wakeIn);

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (cpuResume === 1'b1) resCnt++;
      if (wakeResetReq === 1'b1) rstCnt++;
      if (cyc == 8000) begin
         errorCnt++;
         results();
      end
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      testsRun++;
      if (got !== exp) begin
         errorCnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wr(input logic [11:0] a, input logic [7:0] v);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {24'h0, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge mclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      @(posedge mclk);
   endtask
   task rd(input logic [11:0] a, output logic [31:0] d);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge mclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      s_axi_rready <= 1'b0;
      @(posedge mclk);
   endtask
   task rst();
      arst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      arst_n <= 1'b1;
      @(posedge mclk);
   endtask
   // enter power-down, pulse one source, judge the wake; a device expected to stay asleep is reset
   task automatic tWake(input logic [7:0] ctrl, input logic [2:0] src, input logic [7:0] len,
                        input logic expW);
      int          c;
      int          r0;
      int          w0;
      logic [31:0] d;
      r0 = resCnt;
      w0 = rstCnt;
      wr(A_CTRL, ctrl | 8'h02);
      repeat (2) @(posedge mclk);
      chk(32'(powerDown), 32'h1);
      chk(32'(portHold), 32'h1);
      pReq <= src;
      pLen <= len;
      @(posedge mclk);
      pReq <= 3'h0;
      c = 0;
      while (cpuClkEn !== 1'b1 && c < 80) begin
         @(posedge mclk);
         c++;
      end
      chk(32'(c < 80), 32'(expW));
      if (!expW) rst();
      else begin
         chk(32'(resCnt - r0), 32'(!ctrl[4]));
         chk(32'(rstCnt - w0), 32'(ctrl[4]));
         if (!ctrl[4]) chk(32'(wakeSource), 32'(src));
         if (!ctrl[4]) chk(32'(c >= RC + OC && c <= RC + OC + 12), 32'h1);
         rd(A_CTRL, d);
         chk(32'(d[1]), 32'h0);
      end
   endtask
   task results();
      if (errorCnt == 0 && testsRun > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      logic [31:0] d;
      arst_n = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, pReq, pLen, wake_edge_mode} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {protectActive, rtcEnableSet} = '0;
      wakePinActiveHigh = 1'b1;
      s_axi_wstrb = 4'h1;
      repeat (5) @(posedge mclk);
      arst_n <= 1'b1;
      @(posedge mclk);
      rd(A_GATE, d);
      chk(d, 32'hff);
      rd(A_CTRL, d);
      chk(d, 32'h01);
      wr(A_GATE, 8'h5a);
      rd(A_GATE, d);
      chk(d, 32'h5a);
      wr(A_CTRL, 8'hed);
      rd(A_CTRL, d);
      chk(d, 32'h0d);
      rd(12'h004, d);
      chk(d & 32'hffffff00, 32'h0);
      protectActive <= 1'b1;
      wr(A_CTRL, 8'h03);
      repeat (3) @(posedge mclk);
      chk(32'(powerDown), 32'h0);
      protectActive <= 1'b0;
      tWake(8'h01, 3'b001, 8'h4, 1'b1);
      chk(32'(rtcStopped), 32'h1);
      rtcEnableSet <= 1'b1;
      @(posedge mclk);
      rtcEnableSet <= 1'b0;
      repeat (2) @(posedge mclk);
      chk(32'(rtcStopped), 32'h0);
      tWake(8'h01, 3'b010, 8'h5, 1'b0);
      tWake(8'h05, 3'b100, 8'h5, 1'b1);
      tWake(8'h09, 3'b100, 8'h5, 1'b0);
      tWake(8'h0d, 3'b010, 8'h5, 1'b1);
      tWake(8'h09, 3'b001, 8'h1, 1'b0);
      tWake(8'h08, 3'b001, 8'h5, 1'b0);
      wake_edge_mode <= `PDW_EDGE_NOWAKE;
      tWake(8'h01, 3'b001, 8'h5, 1'b0);
      wake_edge_mode <= 2'h0;
      tWake(8'h11, 3'b001, 8'h5, 1'b1);
      results();
   end
endmodule
